// File: core/rtccs_pkg.sv
package rtccs_pkg;

    // Register indices on the multiplexed bus
    localparam logic [7:0] ADDR_SEC      = 8'h00;
    localparam logic [7:0] ADDR_SEC_ALM  = 8'h01;
    localparam logic [7:0] ADDR_MIN      = 8'h02;
    localparam logic [7:0] ADDR_MIN_ALM  = 8'h03;
    localparam logic [7:0] ADDR_HOUR     = 8'h04;
    localparam logic [7:0] ADDR_HOUR_ALM = 8'h05;
    localparam logic [7:0] ADDR_DOW      = 8'h06;
    localparam logic [7:0] ADDR_DOM      = 8'h07;
    localparam logic [7:0] ADDR_MONTH    = 8'h08;
    localparam logic [7:0] ADDR_YEAR     = 8'h09;
    localparam logic [7:0] ADDR_RATE_OSC = 8'h0a;
    localparam logic [7:0] ADDR_INT_FMT  = 8'h0b;
    localparam logic [7:0] ADDR_EVT_STAT = 8'h0c;
    localparam logic [7:0] ADDR_ALM_DAY  = 8'h0d;

    // Oscillator control codes
    localparam logic [2:0] OSC_RUN_RESTART = 3'h2;
    localparam logic [2:0] OSC_RUN_KEEP    = 3'h3;

    // Values after power-on reset
    localparam logic [2:0] OSC_RESET   = 3'h0;
    localparam logic [3:0] RATE_RESET  = 4'h0;
    localparam logic [7:0] ALARM_RESET = 8'h00;
    localparam logic [5:0] DAY_RESET   = 6'h00;

    // Timebase
    localparam int unsigned CORE_CLK_HZ   = 200_000_000;
    localparam int unsigned TICK_HZ       = 32_768;
    localparam logic [14:0] DIV_LAST      = 15'h7fff;
    localparam logic [14:0] DIV_HALF      = 15'h4000;
    localparam logic [14:0] UIP_LEAD      = 15'h0008;
    localparam int unsigned WP_RECOVERY_MS = 20;
    localparam int unsigned WP_RECOVERY_CYCLES = CORE_CLK_HZ / 1000 * WP_RECOVERY_MS;

    // Calendar constants
    localparam logic [7:0] SUNDAY   = 8'h01;
    localparam logic [7:0] APRIL    = 8'h04;
    localparam logic [7:0] OCTOBER  = 8'h0a;
    localparam logic [7:0] DECEMBER = 8'h0c;
    localparam logic [7:0] FEBRUARY = 8'h02;

endpackage

// File: core/rtccs_tick_gen.sv
`timescale 1ns/100ps
module rtccs_tick_gen #(
    parameter int unsigned CLK_HZ  = rtccs_pkg::CORE_CLK_HZ,
    parameter int unsigned TICK_HZ = rtccs_pkg::TICK_HZ
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_b_i,
    // Control and tick
    input  wire logic run_i,
    output logic      tick_o
);

    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic        wrap;
    logic        tick_q;

    // Fractional accumulator keeps long-term rate exact
    assign wrap  = acc_q >= (CLK_HZ - TICK_HZ);
    assign acc_d = !run_i ? acc_q : wrap ? acc_q + TICK_HZ - CLK_HZ : acc_q + TICK_HZ;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_q  <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            tick_q <= run_i && wrap;
        end
    end

    assign tick_o = tick_q;

endmodule

// File: core/rtccs_core.sv
`timescale 1ns/100ps
// Overview of operation
// - Update end sets update-ended flag
// - Update interrupt needs enable and no inhibit
// - Next update at least 999ms later
// - UPDATE_IN_PROGRESS low guarantees update-free lead time
// - Codes 010/011 run oscillator and divider
// - Code 11X holds divider at zero; others stop
// - Writing 010 gives first update 500ms
// - Power fail blocks writes plus recovery
// - UPDATE_IN_PROGRESS read-only, set before, cleared after
// - Low nibble selects periodic period
// - Daylight saving fall-back and spring-forward
// - Hour format and numeric format bits
// - Inhibit blocks transfer, clears update enable
// - Periodic and alarm flags set on events
// - Status read clears flags; low bits zero
// - Request flag from flag and enable
// - Valid-backup bit read-only; bit6 zero
// - Alarm day field, zero disables, reset-kept
// - Read-only bits and status ignore writes
// - Device reset clears enables and flags
// - Control registers always readable; writes blocked during power fail plus recovery
// - Rate table doubling, codes 1/2 aliases
module rtccs_core #(
    parameter int unsigned CLK_HZ      = rtccs_pkg::CORE_CLK_HZ,
    parameter int unsigned WP_RECOVERY = rtccs_pkg::WP_RECOVERY_CYCLES
) (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    // Multiplexed host bus
    input  wire logic [7:0] ad_i,
    output logic      [7:0] ad_o,
    output logic            ad_oe_b_o,
    input  wire logic       as_i,
    input  wire logic       ds_i,
    input  wire logic       rw_i,
    input  wire logic       cs_b_i,
    input  wire logic       extended_storage_select_i,
    input  wire logic       device_reset_b_i,
    // Supply monitor
    input  wire logic       power_fail_i,
    input  wire logic       backup_cell_valid_i,
    // Interrupt pin, open drain
    output logic            irq_o,
    output logic            irq_oe_b_o
);

    // Bus sampling
    logic       as_q, ds_q, wr_q, rd_c_q;
    logic [7:0] ad_q, addr_q, rd_q;
    logic       oe_b_q;
    // Control and status
    logic [2:0] osc_q;
    logic [3:0] rate_q;
    logic       uti_q, pie_q, aie_q, uie_q, spare_q, df_q, hf_q, dse_q;
    logic       irq_request_flag_q, pf_q, af_q, uf_q, uip_q, vrt_q;
    logic [5:0] day_q;
    // Timekeeping, held in binary; alarm bytes kept as written
    logic [7:0] sec_q, min_q, hr_q, dow_q, dom_q, mon_q, yr_q;
    logic [7:0] asec_q, amin_q, ahr_q;
    logic       dst_done_q;
    logic [14:0] div_q;
    logic [31:0] wp_cnt_q;

    // Format conversion between internal binary and user byte
    function automatic logic [7:0] to_user(input logic [7:0] v, input logic hour, input logic df, input logic hf);
        logic [7:0] h;
        logic       pm;
        h  = v;
        pm = 1'b0;
        if (hour && !hf) begin
            pm = v >= 8'd12;
            h  = (v == 8'd0 || v == 8'd12) ? 8'd12 : (pm ? v - 8'd12 : v);
        end
        if (!df)
            h = {h[3:0] == 4'h0 ? 4'h0 : 4'h0, 4'h0} | (((h / 8'd10) << 4) | (h % 8'd10));
        return {pm | h[7], h[6:0]};
    endfunction

    function automatic logic [7:0] from_user(input logic [7:0] b, input logic hour, input logic df, input logic hf);
        logic [7:0] raw;
        logic [7:0] v;
        raw = (hour && !hf) ? {1'b0, b[6:0]} : b;
        v   = df ? raw : 8'((raw[7:4] * 4'd10) + {4'h0, raw[3:0]});
        if (hour && !hf)
            v = ((v == 8'd12) ? 8'd0 : v) + (b[7] ? 8'd12 : 8'd0);
        return v;
    endfunction

    // Bus decode
    wire        bus_sel   = !cs_b_i && !extended_storage_select_i;
    wire        rd_active = bus_sel && ds_i && rw_i;
    wire        ds_fall   = ds_q && !ds_i;
    wire        wp        = power_fail_i || (wp_cnt_q != 32'h0000_0000);
    wire        wr_stb    = ds_fall && wr_q && !wp;
    wire        clr_c     = ds_fall && rd_c_q;
    wire        wr_a      = wr_stb && addr_q == rtccs_pkg::ADDR_RATE_OSC;
    wire        wr_b      = wr_stb && addr_q == rtccs_pkg::ADDR_INT_FMT;
    wire        wr_d      = wr_stb && addr_q == rtccs_pkg::ADDR_ALM_DAY;
    wire [2:0]  osc_new   = ad_q[6:4];

    // Oscillator and divider
    wire        osc_on    = (osc_q == rtccs_pkg::OSC_RUN_RESTART) || (osc_q == rtccs_pkg::OSC_RUN_KEEP)
                            || (osc_q[2:1] == 2'b11);
    wire        div_run   = (osc_q == rtccs_pkg::OSC_RUN_RESTART) || (osc_q == rtccs_pkg::OSC_RUN_KEEP);
    wire        tick;
    wire        sec_evt   = div_run && tick && div_q == rtccs_pkg::DIV_LAST;
    wire        upd_evt   = sec_evt && !uti_q;

    rtccs_tick_gen #(
        .CLK_HZ  (CLK_HZ),
        .TICK_HZ (rtccs_pkg::TICK_HZ)
    ) u_tick (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .run_i      (osc_on),
        .tick_o     (tick)
    );

    // Periodic rate: codes 3..15 give 2^(code-1) ticks, 1 and 2 alias 8 and 9
    wire [3:0]  rate_eff  = (rate_q == 4'h1) ? 4'h8 : (rate_q == 4'h2) ? 4'h9 : rate_q;
    wire [14:0] per_mask  = 15'((16'h0001 << (rate_eff - 4'h1)) - 16'h0001);
    wire        per_evt   = div_run && tick && rate_q != 4'h0 && (div_q & per_mask) == per_mask;

    // Next calendar values on an update cycle
    logic [7:0] n_sec, n_min, n_hr, n_dow, n_dom, n_mon, n_yr, mdays;
    logic       n_dst;
    wire        sunday    = dow_q == rtccs_pkg::SUNDAY;
    wire        fall_back = dse_q && !dst_done_q && sunday && mon_q == rtccs_pkg::OCTOBER
                            && dom_q >= 8'd25 && hr_q == 8'd1;
    wire        spring    = dse_q && sunday && mon_q == rtccs_pkg::APRIL && dom_q <= 8'd7 && hr_q == 8'd1;

    always_comb begin
        case (mon_q)
            8'd4, 8'd6, 8'd9, 8'd11: mdays = 8'd30;
            rtccs_pkg::FEBRUARY:     mdays = (yr_q[1:0] == 2'b00) ? 8'd29 : 8'd28;
            default:                 mdays = 8'd31;
        endcase
    end

    always_comb begin
        n_sec = sec_q + 8'd1;
        n_min = min_q;
        n_hr  = hr_q;
        n_dow = dow_q;
        n_dom = dom_q;
        n_mon = mon_q;
        n_yr  = yr_q;
        n_dst = dst_done_q;
        if (sec_q >= 8'd59) begin
            n_sec = 8'd0;
            n_min = min_q + 8'd1;
            if (min_q >= 8'd59) begin
                n_min = 8'd0;
                if (fall_back) begin
                    n_hr  = 8'd1;
                    n_dst = 1'b1;
                end else if (spring) begin
                    n_hr  = 8'd3;
                end else if (hr_q < 8'd23) begin
                    n_hr  = hr_q + 8'd1;
                end else begin
                    n_hr  = 8'd0;
                    n_dst = 1'b0;
                    n_dow = (dow_q >= 8'd7) ? 8'd1 : dow_q + 8'd1;
                    n_dom = dom_q + 8'd1;
                    if (dom_q >= mdays) begin
                        n_dom = 8'd1;
                        n_mon = mon_q + 8'd1;
                        if (mon_q >= rtccs_pkg::DECEMBER) begin
                            n_mon = 8'd1;
                            n_yr  = (yr_q >= 8'd99) ? 8'd0 : yr_q + 8'd1;
                        end
                    end
                end
            end
        end
    end

    // Alarm check on the freshly advanced time; 11 in the top bits is don't care
    wire [7:0]  u_sec     = to_user(n_sec, 1'b0, df_q, hf_q);
    wire [7:0]  u_min     = to_user(n_min, 1'b0, df_q, hf_q);
    wire [7:0]  u_hr      = to_user(n_hr, 1'b1, df_q, hf_q);
    wire [7:0]  u_dom     = to_user(n_dom, 1'b0, df_q, hf_q);
    wire        alm_match = (asec_q[7:6] == 2'b11 || asec_q == u_sec)
                            && (amin_q[7:6] == 2'b11 || amin_q == u_min)
                            && (ahr_q[7:6] == 2'b11 || ahr_q == u_hr)
                            && (day_q == 6'h00 || day_q == u_dom[5:0]);
    wire        alm_evt   = upd_evt && alm_match;

    // Event flags: set wins over a clearing read, device reset wins over both
    wire        dev_rst   = !device_reset_b_i;
    wire        uf_d      = !dev_rst && (upd_evt || (uf_q && !clr_c));
    wire        pf_d      = !dev_rst && (per_evt || (pf_q && !clr_c));
    wire        af_d      = !dev_rst && (alm_evt || (af_q && !clr_c));
    wire        uti_d     = wr_b ? ad_q[7] : uti_q;
    wire        uie_d     = !dev_rst && !uti_d && (wr_b ? ad_q[4] : uie_q);
    wire        pie_d     = !dev_rst && (wr_b ? ad_q[6] : pie_q);
    wire        aie_d     = !dev_rst && (wr_b ? ad_q[5] : aie_q);
    wire        req       = (af_d && aie_d) || (pf_d && pie_d) || (uf_d && uie_d && !uti_d);
    wire        irq_request_flag_d    = !dev_rst && (req || (irq_request_flag_q && !clr_c));
    wire        uip_d     = div_run && !uti_d && !sec_evt
                            && div_q >= (rtccs_pkg::DIV_LAST - rtccs_pkg::UIP_LEAD + 15'h0001);

    // Read data mux
    logic [7:0] rd_d;
    always_comb begin
        case (addr_q)
            rtccs_pkg::ADDR_SEC:      rd_d = to_user(sec_q, 1'b0, df_q, hf_q);
            rtccs_pkg::ADDR_SEC_ALM:  rd_d = asec_q;
            rtccs_pkg::ADDR_MIN:      rd_d = to_user(min_q, 1'b0, df_q, hf_q);
            rtccs_pkg::ADDR_MIN_ALM:  rd_d = amin_q;
            rtccs_pkg::ADDR_HOUR:     rd_d = to_user(hr_q, 1'b1, df_q, hf_q);
            rtccs_pkg::ADDR_HOUR_ALM: rd_d = ahr_q;
            rtccs_pkg::ADDR_DOW:      rd_d = to_user(dow_q, 1'b0, df_q, hf_q);
            rtccs_pkg::ADDR_DOM:      rd_d = to_user(dom_q, 1'b0, df_q, hf_q);
            rtccs_pkg::ADDR_MONTH:    rd_d = to_user(mon_q, 1'b0, df_q, hf_q);
            rtccs_pkg::ADDR_YEAR:     rd_d = to_user(yr_q, 1'b0, df_q, hf_q);
            rtccs_pkg::ADDR_RATE_OSC: rd_d = {uip_q, osc_q, rate_q};
            rtccs_pkg::ADDR_INT_FMT:  rd_d = {uti_q, pie_q, aie_q, uie_q, spare_q, df_q, hf_q, dse_q};
            rtccs_pkg::ADDR_EVT_STAT: rd_d = {irq_request_flag_q, pf_q, af_q, uf_q, 4'h0};
            rtccs_pkg::ADDR_ALM_DAY:  rd_d = {vrt_q, 1'b0, day_q};
            default:                  rd_d = 8'h00;
        endcase
    end

    // Bus front end
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            as_q   <= 1'b0;
            ds_q   <= 1'b0;
            wr_q   <= 1'b0;
            rd_c_q <= 1'b0;
            ad_q   <= 8'h00;
            addr_q <= 8'h00;
            rd_q   <= 8'h00;
            oe_b_q <= 1'b1;
        end else begin
            as_q   <= as_i;
            ds_q   <= ds_i;
            wr_q   <= bus_sel && !rw_i;
            rd_c_q <= rd_active && addr_q == rtccs_pkg::ADDR_EVT_STAT;
            ad_q   <= ad_i;
            if (as_q && !as_i)
                addr_q <= ad_i;
            rd_q   <= rd_d;
            oe_b_q <= !rd_active;
        end
    end

    // Control and status registers
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            osc_q  <= rtccs_pkg::OSC_RESET;
            rate_q <= rtccs_pkg::RATE_RESET;
            {uti_q, pie_q, aie_q, uie_q, spare_q, df_q, hf_q, dse_q} <= 8'h00;
            {irq_request_flag_q, pf_q, af_q, uf_q, uip_q, vrt_q} <= 6'h00;
            day_q  <= rtccs_pkg::DAY_RESET;
        end else begin
            if (wr_a) begin
                osc_q  <= osc_new;
                rate_q <= ad_q[3:0];
            end
            uti_q <= uti_d;
            pie_q <= pie_d;
            aie_q <= aie_d;
            uie_q <= uie_d;
            if (wr_b)
                {spare_q, df_q, hf_q, dse_q} <= ad_q[3:0];
            if (wr_b && dev_rst)
                spare_q <= 1'b0;
            irq_request_flag_q <= irq_request_flag_d;
            pf_q   <= pf_d;
            af_q   <= af_d;
            uf_q   <= uf_d;
            uip_q  <= uip_d;
            vrt_q  <= backup_cell_valid_i;
            if (wr_d)
                day_q <= ad_q[5:0];
        end
    end

    // Divider, write protection and time bytes
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_q      <= 15'h0000;
            wp_cnt_q   <= 32'h0000_0000;
            dst_done_q <= 1'b0;
            {sec_q, min_q, hr_q, yr_q} <= 32'h0000_0000;
            {dow_q, dom_q, mon_q} <= 24'h010101;
            {asec_q, amin_q, ahr_q} <= {3{rtccs_pkg::ALARM_RESET}};
        end else begin
            if (power_fail_i)
                wp_cnt_q <= 32'(WP_RECOVERY);
            else if (wp_cnt_q != 32'h0000_0000)
                wp_cnt_q <= wp_cnt_q - 32'h0000_0001;
            if (wr_a && osc_new == rtccs_pkg::OSC_RUN_RESTART)
                div_q <= rtccs_pkg::DIV_HALF;
            else if (osc_q[2:1] == 2'b11)
                div_q <= 15'h0000;
            else if (div_run && tick)
                div_q <= div_q + 15'h0001;
            if (upd_evt) begin
                {sec_q, min_q, hr_q, dow_q} <= {n_sec, n_min, n_hr, n_dow};
                {dom_q, mon_q, yr_q} <= {n_dom, n_mon, n_yr};
                dst_done_q <= n_dst;
            end
            if (wr_stb) begin
                case (addr_q)
                    rtccs_pkg::ADDR_SEC:      sec_q  <= from_user(ad_q, 1'b0, df_q, hf_q);
                    rtccs_pkg::ADDR_SEC_ALM:  asec_q <= ad_q;
                    rtccs_pkg::ADDR_MIN:      min_q  <= from_user(ad_q, 1'b0, df_q, hf_q);
                    rtccs_pkg::ADDR_MIN_ALM:  amin_q <= ad_q;
                    rtccs_pkg::ADDR_HOUR:     hr_q   <= from_user(ad_q, 1'b1, df_q, hf_q);
                    rtccs_pkg::ADDR_HOUR_ALM: ahr_q  <= ad_q;
                    rtccs_pkg::ADDR_DOW:      dow_q  <= from_user(ad_q, 1'b0, df_q, hf_q);
                    rtccs_pkg::ADDR_DOM:      dom_q  <= from_user(ad_q, 1'b0, df_q, hf_q);
                    rtccs_pkg::ADDR_MONTH:    mon_q  <= from_user(ad_q, 1'b0, df_q, hf_q);
                    rtccs_pkg::ADDR_YEAR:     yr_q   <= from_user(ad_q, 1'b0, df_q, hf_q);
                    default:                  ;
                endcase
            end
        end
    end

    // Pins; interrupt pulls low while a request is pending
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o      <= 1'b0;
            irq_oe_b_o <= 1'b1;
        end else begin
            irq_o      <= 1'b0;
            irq_oe_b_o <= !irq_request_flag_q;
        end
    end

    assign ad_o      = rd_q;
    assign ad_oe_b_o = oe_b_q;

endmodule

// File: verification/rtccs_core_props.sv
`timescale 1ns/100ps
module rtccs_core_props #(
    parameter int unsigned CLK_HZ      = 32768,
    parameter int unsigned WP_RECOVERY = 16
) (
    input wire logic       core_clk_i,
    input wire logic       rst_b_i,
    input wire logic [7:0] ad_i,
    input wire logic [7:0] ad_o,
    input wire logic       ad_oe_b_o,
    input wire logic       as_i,
    input wire logic       ds_i,
    input wire logic       rw_i,
    input wire logic       cs_b_i,
    input wire logic       extended_storage_select_i,
    input wire logic       device_reset_b_i,
    input wire logic       power_fail_i,
    input wire logic       backup_cell_valid_i,
    input wire logic       irq_o,
    input wire logic       irq_oe_b_o
);
    logic       as_q;
    logic [7:0] addr_q;
    logic       sel_c;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            as_q   <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            as_q <= as_i;
            if (as_q && !as_i) begin
                addr_q <= ad_i;
            end
        end
    end
    assign sel_c = (addr_q == 8'h0c);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    AST_IRQ_PIN_LOW:
    assert property (irq_o == 1'b0) else $error("irq data not low");
    AST_RD_DRIVE:
    assert property ($rose(ds_i) && rw_i && !cs_b_i && !extended_storage_select_i |=> !ad_oe_b_o)
        else $error("read not driven");
    AST_RD_RELEASE:
    assert property ($fell(ds_i) |=> ad_oe_b_o) else $error("bus held after read");
    AST_WR_QUIET:
    assert property (ds_i && !rw_i && !$past(rw_i) |-> ad_oe_b_o) else $error("bus driven in write");
    AST_EXT_QUIET:
    assert property (extended_storage_select_i && $past(extended_storage_select_i, 2) |-> ad_oe_b_o)
        else $error("bus driven with extended select");
    AST_CLR_RELEASE:
    assert property ($fell(ds_i) && sel_c && $past(rw_i) && !$past(cs_b_i)
        && !$past(extended_storage_select_i) |-> ##[1:2] irq_oe_b_o) else $error("irq kept after status read");
    AST_C_LOW_ZERO:
    assert property (!ad_oe_b_o && sel_c |-> ad_o[3:0] == 4'h0) else $error("status low bits set");
    AST_D_BIT6_ZERO:
    assert property (!ad_oe_b_o && addr_q == 8'h0d |-> ad_o[6] == 1'b0) else $error("alarm day bit 6 set");
    AST_IRQ_HOLD:
    assert property (!irq_oe_b_o && device_reset_b_i && $past(device_reset_b_i) && $past(device_reset_b_i, 2)
        && !(sel_c && (ds_i || $past(ds_i) || $past(ds_i, 2))) |=> !irq_oe_b_o) else $error("irq dropped");
    cover property (!irq_oe_b_o);
    cover property ($fell(ds_i) && sel_c);
    cover property (power_fail_i && ds_i);
endmodule

bind rtccs_core rtccs_core_props #(.CLK_HZ(CLK_HZ), .WP_RECOVERY(WP_RECOVERY)) u_props (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_b_o(ad_oe_b_o),
    .as_i(as_i), .ds_i(ds_i), .rw_i(rw_i), .cs_b_i(cs_b_i),
    .extended_storage_select_i(extended_storage_select_i), .device_reset_b_i(device_reset_b_i),
    .power_fail_i(power_fail_i), .backup_cell_valid_i(backup_cell_valid_i),
    .irq_o(irq_o), .irq_oe_b_o(irq_oe_b_o));

// File: verification/rtccs_host.sv
`timescale 1ns/100ps
module rtccs_host (
    // Clock and bus view
    input  wire logic       core_clk_i,
    input  wire logic [7:0] ad_bus_i,
    input  wire logic       ad_oe_b_i,
    // Host drive
    output logic      [7:0] ad_o,
    output logic            as_o,
    output logic            ds_o,
    output logic            rw_o,
    output logic            cs_b_o,
    output logic            ext_sel_o
);
    initial begin
        ad_o      = 8'h00;
        as_o      = 1'b0;
        ds_o      = 1'b0;
        rw_o      = 1'b1;
        cs_b_o    = 1'b1;
        ext_sel_o = 1'b0;
    end
    // Read data is unknown when the device never drove the bus
    task automatic access(input logic wr, input logic ext, input logic [7:0] addr,
                          input logic [7:0] wd, output logic [7:0] rd);
        @(posedge core_clk_i);
        as_o      <= 1'b1;
        ad_o      <= addr;
        rw_o      <= !wr;
        cs_b_o    <= 1'b0;
        ext_sel_o <= ext;
        @(posedge core_clk_i);
        as_o <= 1'b0;
        @(posedge core_clk_i);
        ds_o <= 1'b1;
        ad_o <= wr ? wd : ~addr;
        repeat (3) @(posedge core_clk_i);
        rd = ad_oe_b_i ? 8'hxx : ad_bus_i;
        ds_o <= 1'b0;
        @(posedge core_clk_i);
        cs_b_o    <= 1'b1;
        ext_sel_o <= 1'b0;
        ad_o      <= ~ad_o;
    endtask
endmodule

// File: verification/rtccs_core_tb_top.sv
`timescale 1ns/100ps
module rtccs_core_tb_top;
    localparam int unsigned CLK_HZ = 32768;
    localparam int unsigned WP_REC = 16;
    localparam int          CPT    = CLK_HZ / rtccs_pkg::TICK_HZ;
    logic        core_clk;
    logic        rst_b;
    logic        dev_rst_b;
    logic        power_fail;
    logic        backup_valid;
    logic [7:0]  host_ad;
    logic [7:0]  dut_ad;
    logic [7:0]  ad_bus;
    logic        ad_oe_b;
    logic        as_s, ds_s, rw_s, cs_b_s, ext_sel, irq, irq_oe_b;
    int          err_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          mdl [4];
    int          t1;
    int          codes [3] = '{1, 6, 7};
    logic [15:0] rnd = 16'hdbab;

    assign ad_bus = ad_oe_b ? host_ad : dut_ad;

    rtccs_core #(.CLK_HZ(CLK_HZ), .WP_RECOVERY(WP_REC)) DUT (
        .core_clk_i(core_clk), .rst_b_i(rst_b), .ad_i(ad_bus), .ad_o(dut_ad), .ad_oe_b_o(ad_oe_b),
        .as_i(as_s), .ds_i(ds_s), .rw_i(rw_s), .cs_b_i(cs_b_s), .extended_storage_select_i(ext_sel),
        .device_reset_b_i(dev_rst_b), .power_fail_i(power_fail), .backup_cell_valid_i(backup_valid),
        .irq_o(irq), .irq_oe_b_o(irq_oe_b));

    rtccs_host u_host (
        .core_clk_i(core_clk), .ad_bus_i(ad_bus), .ad_oe_b_i(ad_oe_b), .ad_o(host_ad),
        .as_o(as_s), .ds_o(ds_s), .rw_o(rw_s), .cs_b_o(cs_b_s), .ext_sel_o(ext_sel));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int per_ticks(input int code);
        return (code < 3) ? (64 << code) : (1 << (code - 1));
    endfunction
    function automatic logic [7:0] exp_of(input logic [7:0] a);
        case (a)
            8'h0a: return 8'(mdl[0]);
            8'h0b: return 8'(mdl[1]);
            8'h0d: return {backup_valid, 1'b0, 6'(mdl[3])};
            default: return 8'h00;
        endcase
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Model follows only writes the device may take
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic take, input logic ext);
        logic [7:0] unused;
        u_host.access(1'b1, ext, a, d, unused);
        if (take && !ext) begin
            case (a)
                8'h0a: mdl[0] = d & 8'h7f;
                8'h0b: mdl[1] = d[7] ? (d & 8'hef) : d;
                8'h0d: mdl[3] = d & 8'h3f;
                default: ;
            endcase
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] rd;
        u_host.access(1'b0, 1'b0, a, 8'h00, rd);
        check($sformatf("reg %h", a), {8'h00, rd}, {8'h00, exp});
    endtask
    task automatic clr_c();
        logic [7:0] rd;
        u_host.access(1'b0, 1'b0, 8'h0c, 8'h00, rd);
        repeat (3) @(posedge core_clk);
    endtask
    task automatic wait_irq(input int bound);
        int n;
        n = 0;
        while (irq_oe_b !== 1'b0 && n < bound) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= bound) begin
            check("irq wait", 16'h0001, 16'h0000);
            tally_and_finish();
        end
    endtask

    initial begin
        rst_b = 1'b0;
        dev_rst_b = 1'b1;
        power_fail = 1'b0;
        backup_valid = 1'b1;
        mdl = '{0, 0, 0, 0};
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 10; i < 14; i++) rd_chk(8'(i), exp_of(8'(i)));
        wr(8'h0b, 8'h9f, 1, 0); rd_chk(8'h0b, exp_of(8'h0b));
        wr(8'h0b, 8'h1e, 1, 0); rd_chk(8'h0b, exp_of(8'h0b));
        wr(8'h0a, 8'hff, 1, 0); rd_chk(8'h0a, exp_of(8'h0a));
        wr(8'h0a, 8'h0f, 1, 0); rd_chk(8'h0a, exp_of(8'h0a));
        wr(8'h0c, 8'hff, 0, 0); rd_chk(8'h0c, 8'h00);
        wr(8'h0d, 8'hff, 1, 0); rd_chk(8'h0d, exp_of(8'h0d));
        rd_chk(8'h3f, 8'h00);
        wr(8'h0b, 8'h55, 1, 1); rd_chk(8'h0b, exp_of(8'h0b));
        power_fail <= 1'b1;
        wr(8'h0b, 8'h02, 0, 0); rd_chk(8'h0b, exp_of(8'h0b));
        power_fail <= 1'b0;
        wr(8'h0b, 8'h04, 0, 0); rd_chk(8'h0b, exp_of(8'h0b));
        repeat (WP_REC) @(posedge core_clk);
        wr(8'h0b, 8'h04, 1, 0); rd_chk(8'h0b, exp_of(8'h0b));
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            backup_valid <= rnd[8];
            wr(8'h0d, rnd[7:0], 1, 0);
            rd_chk(8'h0d, exp_of(8'h0d));
        end
        wr(8'h0b, 8'h10, 1, 0);
        for (int i = 1; i < 6; i += 2) wr(8'(i), (i == 1) ? 8'h01 : 8'hc0, 1, 0);
        wr(8'h0d, 8'h00, 1, 0);
        clr_c();
        wr(8'h0a, 8'h20, 1, 0);
        t1 = cyc;
        wait_irq(17000 * CPT);
        check("first update", 16'(cyc - t1 > 16376 * CPT && cyc - t1 < 16392 * CPT), 16'h0001);
        t1 = cyc;
        rd_chk(8'h0c, 8'hb0);
        rd_chk(8'h0c, 8'h00);
        rd_chk(8'h0a, 8'h20);
        rd_chk(8'h04, 8'h12);
        while (cyc < t1 + 32768 * CPT - 12) @(posedge core_clk);
        rd_chk(8'h0a, 8'ha0);
        wait_irq(64);
        check("update spacing", 16'(cyc - t1), 16'(32768 * CPT));
        rd_chk(8'h0c, 8'h90);
        wr(8'h0b, 8'h40, 1, 0);
        for (int i = 0; i < 3; i++) begin
            wr(8'h0a, 8'h20 | 8'(codes[i]), 1, 0);
            clr_c();
            wait_irq(300 * CPT);
            t1 = cyc;
            rd_chk(8'h0c, 8'hc0);
            repeat (3) @(posedge core_clk);
            wait_irq(300 * CPT);
            check("periodic period", 16'(cyc - t1), 16'(per_ticks(codes[i]) * CPT));
        end
        wr(8'h0a, 8'h20, 1, 0);
        clr_c();
        repeat (300) @(posedge core_clk);
        check("no periodic", {15'h0000, irq_oe_b}, 16'h0001);
        wr(8'h0b, 8'h77, 1, 0);
        wr(8'h0a, 8'h27, 1, 0);
        repeat (70 * CPT) @(posedge core_clk);
        check("irq raised", {15'h0000, irq_oe_b}, 16'h0000);
        wr(8'h0a, 8'h20, 1, 0);
        dev_rst_b <= 1'b0;
        @(posedge core_clk);
        dev_rst_b <= 1'b1;
        mdl[1] = mdl[1] & 8'h8f;
        repeat (3) @(posedge core_clk);
        check("irq after reset", {15'h0000, irq_oe_b}, 16'h0001);
        rd_chk(8'h0b, exp_of(8'h0b));
        rd_chk(8'h0c, 8'h00);
        tally_and_finish();
    end
endmodule
